// >>> verilog/pmir_pkg.sv
/*
   pmir_pkg: register map, field positions, reset values and address
   decode of the power manager interrupt and reset cause registers.
   Assumes a 32-bit AXI4-Lite slave, one aligned word per register.
*/
package pmir_pkg;
   localparam int unsigned PMIR_AW = 8;
   localparam int unsigned PMIR_DW = 32;
   localparam int unsigned PMIR_SEL_W = 3;

   // printed offsets are register indices; byte address is four times
   localparam logic [7:0] PMIR_IDX_EN_CLR = 8'h34;
   localparam logic [7:0] PMIR_IDX_EN_SET = 8'h35;
   localparam logic [7:0] PMIR_IDX_FLAG = 8'h36;
   localparam logic [7:0] PMIR_IDX_CAUSE = 8'h38;

   localparam int unsigned PMIR_BIT_CLOCK_READY = 0;
   localparam int unsigned PMIR_BIT_CLOCK_FAILURE = 1;

   localparam int unsigned PMIR_BIT_POWER_ON = 0;
   localparam int unsigned PMIR_BIT_CORE_BROWNOUT = 1;
   localparam int unsigned PMIR_BIT_IO_BROWNOUT = 2;
   localparam int unsigned PMIR_BIT_PIN_RESET = 4;
   localparam int unsigned PMIR_BIT_WATCHDOG = 5;
   localparam int unsigned PMIR_BIT_SOFTWARE_RESET = 6;

   localparam logic [7:0] PMIR_EN_RST = 8'h00;
   localparam logic [7:0] PMIR_FLAG_RST = 8'h00;
   localparam logic [7:0] PMIR_CAUSE_RST = 8'h01;
   localparam logic [7:0] PMIR_IRQ_MASK = 8'h03;
   localparam logic [7:0] PMIR_SRC_MASK = 8'h76;

   localparam logic [1:0] PMIR_RESP_OKAY = 2'h0;
   localparam logic [1:0] PMIR_RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      PMIR_SEL_EN_CLR,
      PMIR_SEL_EN_SET,
      PMIR_SEL_FLAG,
      PMIR_SEL_CAUSE,
      PMIR_SEL_NONE
   } pmir_sel_type;

   function automatic logic [PMIR_AW-1:0] pmir_byte_addr(
      input logic [7:0] idx);
      pmir_byte_addr = {idx[5:0], 2'b00};
   endfunction

   function automatic pmir_sel_type pmir_decode(
      input logic [PMIR_AW-1:0] addr);
      if (addr == pmir_byte_addr(PMIR_IDX_EN_CLR))
         pmir_decode = PMIR_SEL_EN_CLR;
      else if (addr == pmir_byte_addr(PMIR_IDX_EN_SET))
         pmir_decode = PMIR_SEL_EN_SET;
      else if (addr == pmir_byte_addr(PMIR_IDX_FLAG))
         pmir_decode = PMIR_SEL_FLAG;
      else if (addr == pmir_byte_addr(PMIR_IDX_CAUSE))
         pmir_decode = PMIR_SEL_CAUSE;
      else
         pmir_decode = PMIR_SEL_NONE;
   endfunction
endpackage

// >>> verilog/pmir_axil_slave.sv
/*
   pmir_axil_slave: AXI4-Lite channel handshakes for the register bank.
   Assumes the owner decodes wr_addr and S_AXI_ARADDR combinationally
   and answers wr_err, rd_data and rd_err in the same cycle.
*/
`timescale 1ns/1ns
module pmir_axil_slave
   import pmir_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [PMIR_AW-1:0] awaddr,
   input wire logic awvalid,
   output logic awready,
   input wire logic [PMIR_DW-1:0] wdata,
   input wire logic [3:0] wstrb,
   input wire logic wvalid,
   output logic wready,
   output logic [1:0] bresp,
   output logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   output logic arready,
   output logic [PMIR_DW-1:0] rdata,
   output logic [1:0] rresp,
   output logic rvalid,
   input wire logic rready,
   output logic wr_fire,
   output logic [PMIR_AW-1:0] wr_addr,
   output logic [7:0] wr_data,
   output logic wr_lane0,
   input wire logic wr_err,
   output logic rd_fire,
   input wire logic [7:0] rd_data,
   input wire logic rd_err
);
   logic aw_full_q;
   logic w_full_q;
   logic bvalid_q;
   logic rvalid_q;
   logic [1:0] bresp_q;
   logic [1:0] rresp_q;
   logic [PMIR_DW-1:0] rdata_q;
   logic [PMIR_AW-1:0] aw_addr_q;
   logic [7:0] w_data_q;
   logic w_lane0_q;

   // address and data are parked independently so either may come first
   assign awready = !aw_full_q;
   assign wready = !w_full_q;
   assign wr_fire = aw_full_q && w_full_q && !bvalid_q;
   assign wr_addr = aw_addr_q;
   assign wr_data = w_data_q;
   assign wr_lane0 = w_lane0_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = !rvalid_q;
   assign rd_fire = arvalid && !rvalid_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         aw_full_q <= 1'b0;
         aw_addr_q <= '0;
      end
      else if (awvalid && !aw_full_q)
      begin
         aw_full_q <= 1'b1;
         aw_addr_q <= awaddr;
      end
      else if (wr_fire)
         aw_full_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         w_full_q <= 1'b0;
         w_data_q <= 8'h00;
         w_lane0_q <= 1'b0;
      end
      else if (wvalid && !w_full_q)
      begin
         w_full_q <= 1'b1;
         w_data_q <= wdata[7:0];
         w_lane0_q <= wstrb[0];
      end
      else if (wr_fire)
         w_full_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         bvalid_q <= 1'b0;
         bresp_q <= PMIR_RESP_OKAY;
      end
      else if (wr_fire)
      begin
         bvalid_q <= 1'b1;
         bresp_q <= wr_err ? PMIR_RESP_SLVERR : PMIR_RESP_OKAY;
      end
      else if (bready)
         bvalid_q <= 1'b0;
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rvalid_q <= 1'b0;
         rresp_q <= PMIR_RESP_OKAY;
         rdata_q <= '0;
      end
      else if (rd_fire)
      begin
         rvalid_q <= 1'b1;
         rresp_q <= rd_err ? PMIR_RESP_SLVERR : PMIR_RESP_OKAY;
         rdata_q <= {24'h000000, rd_data};
      end
      else if (rready)
         rvalid_q <= 1'b0;
   end
endmodule

// >>> verilog/pmir_reset_cause.sv
/*
   pmir_reset_cause: last reset source register.
   Assumes source events are one-cycle or level signals synchronous to
   clk, and that rst is the power-on reset of this logic.
*/
`timescale 1ns/1ns
module pmir_reset_cause
   import pmir_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] sources,
   output logic [7:0] cause
);
   logic [7:0] cause_q;
   logic [7:0] hit;

   assign hit = sources & PMIR_SRC_MASK;
   assign cause = cause_q;

   // only the newest source is kept; simultaneous sources all show
   always_ff @(posedge clk)
   begin
      if (rst)
         cause_q <= PMIR_CAUSE_RST;
      else if (|hit)
         cause_q <= hit;
   end
endmodule

// >>> verilog/pmir_top.sv
/*
   pmir_top: power manager interrupt enable, interrupt flag and reset
   cause registers behind an AXI4-Lite slave, with one interrupt line.
   Assumes all inputs synchronous to MCLK; reset sources arrive as
   event inputs, and RESET itself counts as a power-on reset.
*/
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ns
module pmir_top
   import pmir_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESET,
   input wire logic [PMIR_AW-1:0] S_AXI_AWADDR,
   input wire logic S_AXI_AWVALID,
   output logic S_AXI_AWREADY,
   input wire logic [PMIR_DW-1:0] S_AXI_WDATA,
   input wire logic [3:0] S_AXI_WSTRB,
   input wire logic S_AXI_WVALID,
   output logic S_AXI_WREADY,
   output logic [1:0] S_AXI_BRESP,
   output logic S_AXI_BVALID,
   input wire logic S_AXI_BREADY,
   input wire logic [PMIR_AW-1:0] S_AXI_ARADDR,
   input wire logic S_AXI_ARVALID,
   output logic S_AXI_ARREADY,
   output logic [PMIR_DW-1:0] S_AXI_RDATA,
   output logic [1:0] S_AXI_RRESP,
   output logic S_AXI_RVALID,
   input wire logic S_AXI_RREADY,
   input wire logic [PMIR_SEL_W-1:0] CPU_CLOCK_DIVIDER_SELECT,
   input wire logic [PMIR_SEL_W-1:0] CPU_CLOCK_DIVIDER_ACTIVE,
   input wire logic [PMIR_SEL_W-1:0] PERIPHERAL_BUS_CLOCK_SELECT,
   input wire logic [PMIR_SEL_W-1:0] PERIPHERAL_BUS_CLOCK_ACTIVE,
   input wire logic CLOCK_FAILURE_DETECT,
   input wire logic SOFTWARE_RESET_REQUEST,
   input wire logic WATCHDOG_RESET,
   input wire logic PIN_RESET,
   input wire logic BROWNOUT_IO_SUPPLY_RESET,
   input wire logic BROWNOUT_CORE_SUPPLY_RESET,
   output logic IRQ
);
   pmir_sel_type wr_sel;
   pmir_sel_type rd_sel;
   logic wr_fire;
   logic [PMIR_AW-1:0] wr_addr;
   logic [7:0] wr_data;
   logic wr_lane0;
   logic wr_err;
   logic rd_fire;
   logic [7:0] rd_data;
   logic rd_err;
   logic [7:0] wbits;
   logic [7:0] en_clr_bits;
   logic [7:0] en_set_bits;
   logic [7:0] flag_clr_bits;
   logic [7:0] flag_set_bits;
   logic [7:0] en_q;
   logic [7:0] en_d;
   logic [7:0] flag_q;
   logic [7:0] flag_d;
   logic [7:0] sources;
   logic [7:0] cause;
   logic clk_match;
   logic match_q;
   logic ready_event;
   logic irq_q;
   logic rst_d1_q;

   pmir_axil_slave u_bus (
      .clk (MCLK),
      .rst (RESET),
      .awaddr (S_AXI_AWADDR),
      .awvalid (S_AXI_AWVALID),
      .awready (S_AXI_AWREADY),
      .wdata (S_AXI_WDATA),
      .wstrb (S_AXI_WSTRB),
      .wvalid (S_AXI_WVALID),
      .wready (S_AXI_WREADY),
      .bresp (S_AXI_BRESP),
      .bvalid (S_AXI_BVALID),
      .bready (S_AXI_BREADY),
      .arvalid (S_AXI_ARVALID),
      .arready (S_AXI_ARREADY),
      .rdata (S_AXI_RDATA),
      .rresp (S_AXI_RRESP),
      .rvalid (S_AXI_RVALID),
      .rready (S_AXI_RREADY),
      .wr_fire (wr_fire),
      .wr_addr (wr_addr),
      .wr_data (wr_data),
      .wr_lane0 (wr_lane0),
      .wr_err (wr_err),
      .rd_fire (rd_fire),
      .rd_data (rd_data),
      .rd_err (rd_err)
   );

   // write side: only ones on implemented bits of byte lane 0 act
   always_comb
   begin
      wr_sel = pmir_decode(wr_addr);
      wr_err = (wr_sel == PMIR_SEL_NONE);
      wbits = (wr_fire && wr_lane0) ? (wr_data & PMIR_IRQ_MASK) : 8'h00;
      en_clr_bits = (wr_sel == PMIR_SEL_EN_CLR) ? wbits : 8'h00;
      en_set_bits = (wr_sel == PMIR_SEL_EN_SET) ? wbits : 8'h00;
      flag_clr_bits = (wr_sel == PMIR_SEL_FLAG) ? wbits : 8'h00;
   end

   // clock ready fires on the cycle the running clocks reach the
   // programmed selections, not continuously while they match
   assign clk_match =
      (CPU_CLOCK_DIVIDER_ACTIVE == CPU_CLOCK_DIVIDER_SELECT) &&
      (PERIPHERAL_BUS_CLOCK_ACTIVE == PERIPHERAL_BUS_CLOCK_SELECT);
   assign ready_event = clk_match && !match_q;

   always_ff @(posedge MCLK)
   begin
      if (RESET)
         match_q <= 1'b0;
      else
         match_q <= clk_match;
   end

   always_comb
   begin
      flag_set_bits = 8'h00;
      flag_set_bits[PMIR_BIT_CLOCK_READY] = ready_event;
      flag_set_bits[PMIR_BIT_CLOCK_FAILURE] = CLOCK_FAILURE_DETECT;
   end

   // a set arriving with a one-write on the same flag wins
   assign flag_d = (flag_q & ~flag_clr_bits) | flag_set_bits;
   assign en_d = (en_q | en_set_bits) & ~en_clr_bits;

   always_ff @(posedge MCLK)
   begin
      if (RESET)
         flag_q <= PMIR_FLAG_RST;
      else
         flag_q <= flag_d;
   end

   always_ff @(posedge MCLK)
   begin
      if (RESET)
         en_q <= PMIR_EN_RST;
      else
         en_q <= en_d;
   end

   // registered from next values so the line tracks the registers
   always_ff @(posedge MCLK)
   begin
      if (RESET)
         irq_q <= 1'b0;
      else
         irq_q <= |(flag_d & en_d);
   end
   assign IRQ = irq_q;

   always_comb
   begin
      sources = 8'h00;
      sources[PMIR_BIT_SOFTWARE_RESET] = SOFTWARE_RESET_REQUEST;
      sources[PMIR_BIT_WATCHDOG] = WATCHDOG_RESET;
      sources[PMIR_BIT_PIN_RESET] = PIN_RESET;
      sources[PMIR_BIT_IO_BROWNOUT] = BROWNOUT_IO_SUPPLY_RESET;
      sources[PMIR_BIT_CORE_BROWNOUT] = BROWNOUT_CORE_SUPPLY_RESET;
   end

   pmir_reset_cause u_cause (
      .clk (MCLK),
      .rst (RESET),
      .sources (sources),
      .cause (cause)
   );

   // both enable views read the same state
   always_comb
   begin
      rd_sel = pmir_decode(S_AXI_ARADDR);
      rd_err = 1'b0;
      case (rd_sel)
         PMIR_SEL_EN_CLR: rd_data = en_q;
         PMIR_SEL_EN_SET: rd_data = en_q;
         PMIR_SEL_FLAG: rd_data = flag_q;
         PMIR_SEL_CAUSE: rd_data = cause;
         default:
         begin
            rd_data = 8'h00;
            rd_err = 1'b1;
         end
      endcase
   end

   // helper: no reset, so the cycle after release is visible
   always_ff @(posedge MCLK)
   begin
      rst_d1_q <= RESET;
   end

   property p_en_clear;
      @(posedge MCLK) disable iff (RESET)
      en_clr_bits[PMIR_BIT_CLOCK_READY] |=>
         !en_q[PMIR_BIT_CLOCK_READY] &&
         !(IRQ && !(flag_q[1] && en_q[1]));
   endproperty
   a_en_clear: assert property (p_en_clear)
      else $error("enable clear did not drop enable and request");

   property p_zero_write;
      @(posedge MCLK) disable iff (RESET)
      wr_fire && (!wr_lane0 || wr_data[1:0] == 2'b00) |=>
         en_q == $past(en_q) &&
         (flag_q | $past(flag_set_bits)) ==
         ($past(flag_q) | $past(flag_set_bits));
   endproperty
   a_zero_write: assert property (p_zero_write)
      else $error("zero write changed interrupt state");

   property p_en_set;
      @(posedge MCLK) disable iff (RESET)
      en_set_bits[PMIR_BIT_CLOCK_READY] |=>
         en_q[PMIR_BIT_CLOCK_READY] ##1
         (!S_AXI_RVALID || !$past(rd_fire) ||
          ($past(rd_sel) != PMIR_SEL_EN_SET &&
           $past(rd_sel) != PMIR_SEL_EN_CLR) ||
          S_AXI_RDATA[PMIR_BIT_CLOCK_READY]);
   endproperty
   a_en_set: assert property (p_en_set)
      else $error("enable set did not raise clock ready enable");

   property p_irq;
      @(posedge MCLK) disable iff (RESET)
      IRQ == |(flag_q & en_q);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt line disagrees with flags and enables");

   property p_ready_set;
      @(posedge MCLK) disable iff (RESET)
      clk_match && !$past(clk_match) && !$past(RESET) |=>
         flag_q[PMIR_BIT_CLOCK_READY];
   endproperty
   a_ready_set: assert property (p_ready_set)
      else $error("clock ready flag not set after clocks matched");

   property p_ready_hold;
      @(posedge MCLK) disable iff (RESET)
      flag_q[PMIR_BIT_CLOCK_READY] &&
         !flag_clr_bits[PMIR_BIT_CLOCK_READY] |=>
         flag_q[PMIR_BIT_CLOCK_READY];
   endproperty
   a_ready_hold: assert property (p_ready_hold)
      else $error("clock ready flag cleared without a one write");

   property p_cause_reset;
      @(posedge MCLK) disable iff (RESET)
      rst_d1_q |-> cause == PMIR_CAUSE_RST;
   endproperty
   a_cause_reset: assert property (p_cause_reset)
      else $error("reset cause not at power-on value after reset");

   property p_cause_software;
      @(posedge MCLK) disable iff (RESET)
      SOFTWARE_RESET_REQUEST |=> cause[PMIR_BIT_SOFTWARE_RESET];
   endproperty
   a_cause_software: assert property (p_cause_software)
      else $error("software reset request not recorded");

   property p_cause_watchdog;
      @(posedge MCLK) disable iff (RESET)
      WATCHDOG_RESET |=> cause[PMIR_BIT_WATCHDOG];
   endproperty
   a_cause_watchdog: assert property (p_cause_watchdog)
      else $error("watchdog reset not recorded");

   property p_cause_pin;
      @(posedge MCLK) disable iff (RESET)
      PIN_RESET |=> cause[PMIR_BIT_PIN_RESET];
   endproperty
   a_cause_pin: assert property (p_cause_pin)
      else $error("pin reset not recorded");

   property p_cause_io;
      @(posedge MCLK) disable iff (RESET)
      BROWNOUT_IO_SUPPLY_RESET |=> cause[PMIR_BIT_IO_BROWNOUT];
   endproperty
   a_cause_io: assert property (p_cause_io)
      else $error("io supply brownout reset not recorded");

   property p_cause_core;
      @(posedge MCLK) disable iff (RESET)
      BROWNOUT_CORE_SUPPLY_RESET |=> cause[PMIR_BIT_CORE_BROWNOUT];
   endproperty
   a_cause_core: assert property (p_cause_core)
      else $error("core supply brownout reset not recorded");

   property p_failure_enable;
      @(posedge MCLK) disable iff (RESET)
      en_set_bits[PMIR_BIT_CLOCK_FAILURE] |=>
         en_q[PMIR_BIT_CLOCK_FAILURE] [*1] ##0
         (IRQ == flag_q[PMIR_BIT_CLOCK_FAILURE] || flag_q[0]);
   endproperty
   a_failure_enable: assert property (p_failure_enable)
      else $error("enable set did not raise clock failure enable");

   property p_failure_flag;
      @(posedge MCLK) disable iff (RESET)
      CLOCK_FAILURE_DETECT |=> flag_q[PMIR_BIT_CLOCK_FAILURE] ##1
         (flag_q[PMIR_BIT_CLOCK_FAILURE] ||
          $past(flag_clr_bits[PMIR_BIT_CLOCK_FAILURE]));
   endproperty
   a_failure_flag: assert property (p_failure_flag)
      else $error("clock failure flag not set or lost without a clear");
endmodule

// >>> tb/pmir_testbench.sv
/*
   testbench: self-checking bench for pmir_top; register access over
   AXI4-Lite, the interrupt line, clock ready and clock failure flags,
   and the reset cause events.
   Assumes the pmir_pkg register map and the hand-over bus timing.
*/
`timescale 1ns/1ns
module testbench
   import pmir_pkg::*;
   ;
   typedef struct {
      logic wr;
      logic [7:0] addr;
      logic [31:0] data;
      logic [3:0] strb;
      logic [1:0] resp;
      logic [31:0] rdata;
   } pmir_row_type;
   localparam logic [7:0] a_clr = PMIR_IDX_EN_CLR << 2;
   localparam logic [7:0] a_set = PMIR_IDX_EN_SET << 2;
   localparam logic [7:0] a_flag = PMIR_IDX_FLAG << 2;
   localparam logic [7:0] a_cause = PMIR_IDX_CAUSE << 2;
   localparam logic [1:0] ok = PMIR_RESP_OKAY;
   localparam logic [1:0] er = PMIR_RESP_SLVERR;
   logic mclk, reset, awvalid, wvalid, bready, arvalid, rready, cfd;
   logic [PMIR_AW-1:0] awaddr, araddr;
   logic [31:0] wdata;
   logic [3:0] wstrb;
   logic [PMIR_SEL_W-1:0] cpu_sel, cpu_act, pb_sel, pb_act;
   logic [4:0] evt;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int mismatches = 0;
   int checked = 0;
   int cbit [5] = '{PMIR_BIT_SOFTWARE_RESET, PMIR_BIT_WATCHDOG,
      PMIR_BIT_PIN_RESET, PMIR_BIT_IO_BROWNOUT, PMIR_BIT_CORE_BROWNOUT};
   pmir_row_type rows [0:17] = '{
      '{1'b1, a_set, 32'h1, 4'hf, ok, 32'h0},
      '{1'b0, a_set, 32'h0, 4'h0, ok, 32'h1},
      '{1'b0, a_clr, 32'h0, 4'h0, ok, 32'h1},
      '{1'b1, a_set, 32'h2, 4'hf, ok, 32'h0},
      '{1'b0, a_clr, 32'h0, 4'h0, ok, 32'h3},
      '{1'b1, a_clr, 32'h0, 4'hf, ok, 32'h0},
      '{1'b1, a_set, 32'h0, 4'hf, ok, 32'h0},
      '{1'b0, a_set, 32'h0, 4'h0, ok, 32'h3},
      '{1'b1, a_clr, 32'h2, 4'hf, ok, 32'h0},
      '{1'b0, a_set, 32'h0, 4'h0, ok, 32'h1},
      '{1'b1, a_set, 32'h2, 4'he, ok, 32'h0},
      '{1'b0, a_set, 32'h0, 4'h0, ok, 32'h1},
      '{1'b1, 8'h10, 32'h3, 4'hf, er, 32'h0},
      '{1'b0, 8'h10, 32'h0, 4'h0, er, 32'h0},
      '{1'b1, a_cause, 32'hff, 4'hf, ok, 32'h0},
      '{1'b0, a_cause, 32'h0, 4'h0, ok, 32'h1},
      '{1'b0, a_flag, 32'h0, 4'h0, ok, 32'h0},
      '{1'b1, a_set, 32'h2, 4'hf, ok, 32'h0}};

   pmir_top u_dut (.MCLK(mclk), .RESET(reset),
      .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
      .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
      .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
      .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
      .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
      .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
      .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
      .CPU_CLOCK_DIVIDER_SELECT(cpu_sel), .CPU_CLOCK_DIVIDER_ACTIVE(cpu_act),
      .PERIPHERAL_BUS_CLOCK_SELECT(pb_sel),
      .PERIPHERAL_BUS_CLOCK_ACTIVE(pb_act), .CLOCK_FAILURE_DETECT(cfd),
      .SOFTWARE_RESET_REQUEST(evt[0]), .WATCHDOG_RESET(evt[1]),
      .PIN_RESET(evt[2]), .BROWNOUT_IO_SUPPLY_RESET(evt[3]),
      .BROWNOUT_CORE_SUPPLY_RESET(evt[4]), .IRQ(irq));

   initial
   begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", checked, mismatches);
      if (mismatches == 0 && checked > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // the master holds bready early; both channels are released apart
   task automatic axi_write(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= d;
      wstrb <= s;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while (bvalid !== 1'b1 && n < 50);
      r = bresp;
      bready <= 1'b0;
      if (bvalid !== 1'b1)
      begin
         mismatches++;
         results();
      end
   endtask

   task automatic axi_read(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
      int n;
      n = 0;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do
      begin
         @(posedge mclk);
         n++;
         if (arvalid && arready)
            arvalid <= 1'b0;
      end
      while (rvalid !== 1'b1 && n < 50);
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      if (rvalid !== 1'b1)
      begin
         mismatches++;
         results();
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [1:0] r;
      axi_write(a, d, 4'hf, r);
      check("bresp", {30'h0, r}, {30'h0, ok});
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      logic [1:0] r;
      logic [31:0] d;
      axi_read(a, d, r);
      check("rresp", {30'h0, r}, {30'h0, ok});
      check("rdata", d, e);
   endtask

   // irq is a registered level, so allow a few edges for it to follow
   task automatic wait_irq(input logic e);
      int n;
      n = 0;
      while (irq !== e && n < 16)
      begin
         @(posedge mclk);
         n++;
      end
      check("irq", {31'h0, irq}, {31'h0, e});
      // a line that never follows ends the run here
      if (irq !== e)
         results();
   endtask

   initial
   begin
      logic [1:0] resp;
      logic [31:0] data;
      reset = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready, cfd} = 6'h0;
      awaddr = 8'h0;
      araddr = 8'h0;
      wdata = 32'h0;
      wstrb = 4'h0;
      evt = 5'h0;
      cpu_sel = 3'h2;
      cpu_act = 3'h1;
      pb_sel = 3'h4;
      pb_act = 3'h3;
      repeat (12) @(posedge mclk);
      reset <= 1'b0;
      rd(a_clr, 32'h0);
      rd(a_flag, 32'h0);
      rd(a_cause, {24'h0, PMIR_CAUSE_RST});
      wait_irq(1'b0);
      foreach (rows[i])
      begin
         if (rows[i].wr)
         begin
            axi_write(rows[i].addr, rows[i].data, rows[i].strb, resp);
            check("bresp", {30'h0, resp}, {30'h0, rows[i].resp});
         end
         else
         begin
            axi_read(rows[i].addr, data, resp);
            check("rresp", {30'h0, resp}, {30'h0, rows[i].resp});
            check("rdata", data, rows[i].rdata);
         end
      end
      // only one of the two clocks in place: no ready flag yet
      pb_act <= pb_sel;
      repeat (4) @(posedge mclk);
      rd(a_flag, 32'h0);
      cpu_act <= cpu_sel;
      wait_irq(1'b1);
      rd(a_flag, 32'h1);
      wr(a_flag, 32'h0);
      wr(a_flag, 32'h2);
      rd(a_flag, 32'h1);
      wr(a_clr, 32'h1);
      wait_irq(1'b0);
      wr(a_set, 32'h1);
      wait_irq(1'b1);
      wr(a_flag, 32'h1);
      wait_irq(1'b0);
      rd(a_flag, 32'h0);
      @(posedge mclk);
      cfd <= 1'b1;
      @(posedge mclk);
      cfd <= 1'b0;
      wait_irq(1'b1);
      rd(a_flag, 32'h2);
      wr(a_flag, 32'h2);
      wait_irq(1'b0);
      rd(a_flag, 32'h0);
      for (int i = 0; i < 5; i++)
      begin
         @(posedge mclk);
         evt <= 5'h1 << i;
         @(posedge mclk);
         evt <= 5'h0;
         rd(a_cause, 32'h1 << cbit[i]);
      end
      // two sources in one cycle both show
      @(posedge mclk);
      evt <= 5'h18;
      @(posedge mclk);
      evt <= 5'h0;
      rd(a_cause, (32'h1 << cbit[3]) | (32'h1 << cbit[4]));
      // a second power-on reset in mid-run, clocks parted first and a
      // pending request raised so that reset must withdraw it
      @(posedge mclk);
      cpu_act <= 3'h1;
      cfd <= 1'b1;
      @(posedge mclk);
      cfd <= 1'b0;
      wait_irq(1'b1);
      reset <= 1'b1;
      repeat (2) @(posedge mclk);
      reset <= 1'b0;
      check("irq", {31'h0, irq}, 32'h0);
      rd(a_cause, {24'h0, PMIR_CAUSE_RST});
      rd(a_set, 32'h0);
      results();
   end
endmodule
